// ---- mcr_pkg.sv ----
/*
  Package of the monitor configuration register bank: offsets,
  field positions, reset values and temperature mode codes.
  Assumes an 8-bit register port behind a two-wire bus front end.
*/
`default_nettype none
package mcr_pkg;
  // Register offsets
  localparam logic [7:0] OFS_TEST     = 8'h15;  // Manufacturer test
  localparam logic [7:0] OFS_HOT_LIM  = 8'h39;  // Hot temperature limit
  localparam logic [7:0] OFS_HYST_LIM = 8'h3A;  // Hysteresis limit
  localparam logic [7:0] OFS_STATUS1  = 8'h41;  // First interrupt status
  localparam logic [7:0] OFS_VID_DIV  = 8'h47;  // Voltage id and divisors
  localparam logic [7:0] OFS_BUS_ADDR = 8'h48;  // Bus address
  localparam logic [7:0] OFS_VID_B4   = 8'h49;  // Fifth id bit
  localparam logic [7:0] OFS_TEMP_CFG = 8'h4B;  // Temperature config

  // Field positions
  localparam int POS_FIRST_FAN_TACH_DIV = 4;  // Divisor of the first fan
  localparam int POS_SECOND_FAN_TACH_DIV = 6;  // Divisor of the second fan
  localparam int POS_TEMP_ERR = 4;  // Temperature flag in status
  localparam int POS_TEMP_LSB = 7;  // Ninth temperature bit

  // Reset values
  localparam logic [7:0] RST_TEST     = 8'h00;
  localparam logic [7:0] RST_HOT_LIM  = 8'h7F;
  localparam logic [7:0] RST_HYST_LIM = 8'h00;
  localparam logic [3:0] RST_DIVS     = 4'h0;
  localparam logic [5:0] ADDR_PREFIX  = 6'b001011;
  localparam logic [6:0] RST_VID_B4   = 7'b1000000;
  localparam logic [7:0] RST_TEMP_CFG = 8'h01;

  // Temperature interrupt modes
  typedef enum logic [1:0] {
    MCR_MODE_DEF0 = 2'b00,  // Default mode
    MCR_MODE_ONCE = 2'b01,  // One-time mode
    MCR_MODE_CMP  = 2'b10,  // Comparator mode
    MCR_MODE_DEF1 = 2'b11   // Default mode again
  } mcr_mode_t;

  // One-time mode progress
  typedef enum logic [0:0] {
    MCR_WAIT_HOT  = 1'b0,  // Waiting to exceed hot limit
    MCR_WAIT_COOL = 1'b1   // Waiting to fall under hysteresis
  } mcr_once_t;
endpackage
`default_nettype wire

// ---- mcr_regs.sv ----
/*
  Configuration and status registers of a hardware monitor.
  Assumes a two-wire bus front end that gives one-cycle read and
  write strobes, and a converter that pulses conv_done_i with a
  fresh nine-bit temperature.
*/
// Overview of operation
// RULE_01: Id bits 3:0 read voltage id inputs
// RULE_02: Bits 5:4 set first fan divisor
// RULE_03: Bits 7:6 set second fan divisor
// RULE_04: Address loads 001011 plus both straps
// RULE_05: Fifth id bit, reserved bits reset 1000000
// RULE_06: Equal mode bits: flag above hot limit
// RULE_07: Default mode repeats until below hysteresis
// RULE_08: Mode 01 flags once above hot
// RULE_09: Then flags once below hysteresis
// RULE_10: Read clears flag, conversion may not reset
// RULE_11: Mode 10 alert follows hot compare
// RULE_12: Config bit 7 is ninth temperature bit
// RULE_13: Status bit 4 is the temperature flag
// RULE_14: Status read clears its conditions
// RULE_15: Hot and hysteresis limits at 39h, 3Ah
// RULE_16: Host leaves test register alone
// RULE_17: Limits checked once per conversion
`timescale 1ns/100ps
`default_nettype none
module mcr_regs #(
  parameter int TEMP_W = 9  // Temperature width, ninth bit is the lsb
) (
  input  wire logic       clk_i,                // 200 MHz clock
  input  wire logic       rst_i,                // Async reset, high
  input  wire logic [7:0] reg_addr_i,           // Register offset
  input  wire logic [7:0] reg_wdata_i,          // Write data
  input  wire logic       reg_wr_i,             // Write strobe
  input  wire logic       reg_rd_i,             // Read strobe
  input  wire logic [3:0] voltage_id_inputs_i,  // Low id levels
  input  wire logic       voltage_id_bit4_i,    // Fifth id level
  input  wire logic       addr_strap_high_i,    // Address strap high
  input  wire logic       addr_strap_low_i,     // Address strap low
  input  wire logic [8:0] temp_reading_i,       // Signed half degrees
  input  wire logic       conv_done_i,          // Conversion finished
  output logic      [7:0] reg_rdata_o,          // Read data
  output logic      [1:0] first_fan_div_o,      // First fan divisor
  output logic      [1:0] second_fan_div_o,     // Second fan divisor
  output logic      [7:0] bus_address_o,        // Two-wire address
  output logic            hot_temp_alert_o      // Temperature alert
);

  // Width check
  if (TEMP_W != 9) begin : g_bad_width
    $error("mcr_regs serves a nine-bit temperature only");
  end

  // Stored registers
  logic [7:0] test_ff;       // Manufacturer test
  logic [7:0] hot_lim_ff;    // Hot limit
  logic [7:0] hyst_lim_ff;   // Hysteresis limit
  logic [3:0] divs_ff;       // Both fan divisors
  logic [7:0] addr_ff;       // Bus address
  logic       strap_done_ff; // Straps taken
  logic [6:0] vid_rsv_ff;    // Reserved bits of fifth id register
  logic [6:0] cfg_ff;        // Config bits 6:0
  logic       temp_err_ff;   // Temperature flag
  logic       armed_ff;      // Default mode still hot
  mcr_pkg::mcr_once_t once_ff;  // One-time progress
  logic [8:0] temp_ff;       // Last temperature

  // Decoded strobes
  logic       wr_test;
  logic       wr_hot;
  logic       wr_hyst;
  logic       wr_div;
  logic       wr_addr;
  logic       wr_b4;
  logic       wr_cfg;
  logic       rd_status;
  assign wr_test   = reg_wr_i && reg_addr_i == mcr_pkg::OFS_TEST;
  assign wr_hot    = reg_wr_i && reg_addr_i == mcr_pkg::OFS_HOT_LIM;
  assign wr_hyst   = reg_wr_i && reg_addr_i == mcr_pkg::OFS_HYST_LIM;
  assign wr_div    = reg_wr_i && reg_addr_i == mcr_pkg::OFS_VID_DIV;
  assign wr_addr   = reg_wr_i && reg_addr_i == mcr_pkg::OFS_BUS_ADDR;
  assign wr_b4     = reg_wr_i && reg_addr_i == mcr_pkg::OFS_VID_B4;
  assign wr_cfg    = reg_wr_i && reg_addr_i == mcr_pkg::OFS_TEMP_CFG;
  assign rd_status = reg_rd_i && reg_addr_i == mcr_pkg::OFS_STATUS1;

  // Signed compares on the eight upper temperature bits
  logic       above_hot;
  logic       below_hyst;
  mcr_pkg::mcr_mode_t mode;
  assign above_hot  = $signed(temp_reading_i[8:1]) > $signed(hot_lim_ff);
  assign below_hyst = $signed(temp_reading_i[8:1]) < $signed(hyst_lim_ff);
  assign mode       = mcr_pkg::mcr_mode_t'(cfg_ff[1:0]);

  // Test register, plain storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_ff <= mcr_pkg::RST_TEST;
    end else if (wr_test) begin
      test_ff <= reg_wdata_i;
    end
  end

  // RULE_15: limit registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hot_lim_ff  <= mcr_pkg::RST_HOT_LIM;
      hyst_lim_ff <= mcr_pkg::RST_HYST_LIM;
    end else begin
      if (wr_hot) begin
        hot_lim_ff <= reg_wdata_i;
      end
      if (wr_hyst) begin
        hyst_lim_ff <= reg_wdata_i;
      end
    end
  end

  // RULE_02: fan divisors, RULE_03 alike
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      divs_ff <= mcr_pkg::RST_DIVS;
    end else if (wr_div) begin
      divs_ff <= reg_wdata_i[7:4];
    end
  end

  // RULE_04: straps taken once after release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_ff       <= {mcr_pkg::ADDR_PREFIX, 2'b00};
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      addr_ff       <= {mcr_pkg::ADDR_PREFIX, addr_strap_high_i,
                        addr_strap_low_i};
      strap_done_ff <= 1'b1;
    end else if (wr_addr) begin
      addr_ff <= reg_wdata_i;
    end
  end

  // RULE_05: reserved bits of fifth id register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vid_rsv_ff <= mcr_pkg::RST_VID_B4;
    end else if (wr_b4) begin
      vid_rsv_ff <= reg_wdata_i[7:1];
    end
  end

  // Config mode and reserved bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff <= mcr_pkg::RST_TEMP_CFG[6:0];
    end else if (wr_cfg) begin
      cfg_ff <= reg_wdata_i[6:0];
    end
  end

  // RULE_12: latest temperature kept for bit 7
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      temp_ff <= 9'h000;
    end else if (conv_done_i) begin
      temp_ff <= temp_reading_i;
    end
  end

  // RULE_07: default mode hot tracking
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_ff <= 1'b0;
    end else if (conv_done_i) begin
      if (above_hot) begin
        armed_ff <= 1'b1;
      end else if (below_hyst) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // RULE_09: one-time progress
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      once_ff <= mcr_pkg::MCR_WAIT_HOT;
    end else if (conv_done_i && mode == mcr_pkg::MCR_MODE_ONCE) begin
      unique case (once_ff)
        mcr_pkg::MCR_WAIT_HOT: begin
          if (above_hot) begin
            once_ff <= mcr_pkg::MCR_WAIT_COOL;
          end
        end
        mcr_pkg::MCR_WAIT_COOL: begin
          if (below_hyst) begin
            once_ff <= mcr_pkg::MCR_WAIT_HOT;
          end
        end
      endcase
    end
  end

  // RULE_17: flag set condition per conversion
  logic set_err;
  logic cmp_clear;
  always_comb begin
    set_err   = 1'b0;
    cmp_clear = 1'b0;
    if (conv_done_i) begin
      unique case (mode)
        // RULE_06: default mode sets while hot
        mcr_pkg::MCR_MODE_DEF0,
        mcr_pkg::MCR_MODE_DEF1: begin
          set_err = above_hot || (armed_ff && !below_hyst);
        end
        // RULE_08: one-time crossings
        mcr_pkg::MCR_MODE_ONCE: begin
          set_err = (once_ff == mcr_pkg::MCR_WAIT_HOT) ? above_hot
                                                       : below_hyst;
        end
        // RULE_11: comparator follows hot compare
        mcr_pkg::MCR_MODE_CMP: begin
          set_err   = above_hot;
          cmp_clear = !above_hot;
        end
      endcase
    end
  end

  // RULE_13: status flag, set wins over read clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      temp_err_ff <= 1'b0;
    end else if (set_err) begin
      temp_err_ff <= 1'b1;
    end else if (rd_status || cmp_clear) begin
      // RULE_14: read clears, RULE_10 too
      temp_err_ff <= 1'b0;
    end
  end

  // Read mux, registered
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr_i)
      mcr_pkg::OFS_TEST:     nxt_rdata = test_ff;
      mcr_pkg::OFS_HOT_LIM:  nxt_rdata = hot_lim_ff;
      mcr_pkg::OFS_HYST_LIM: nxt_rdata = hyst_lim_ff;
      mcr_pkg::OFS_STATUS1:  nxt_rdata[mcr_pkg::POS_TEMP_ERR] = temp_err_ff;
      // RULE_01: live id levels
      mcr_pkg::OFS_VID_DIV:  nxt_rdata = {divs_ff, voltage_id_inputs_i};
      mcr_pkg::OFS_BUS_ADDR: nxt_rdata = addr_ff;
      mcr_pkg::OFS_VID_B4:   nxt_rdata = {vid_rsv_ff, voltage_id_bit4_i};
      mcr_pkg::OFS_TEMP_CFG: nxt_rdata = {temp_ff[0], cfg_ff};
      default:               nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_fan_div_o  <= 2'b00;
      second_fan_div_o <= 2'b00;
      bus_address_o    <= {mcr_pkg::ADDR_PREFIX, 2'b00};
      hot_temp_alert_o <= 1'b0;
    end else begin
      first_fan_div_o  <= divs_ff[mcr_pkg::POS_FIRST_FAN_TACH_DIV-4 +: 2];
      second_fan_div_o <= divs_ff[mcr_pkg::POS_SECOND_FAN_TACH_DIV-4 +: 2];
      bus_address_o    <= addr_ff;
      hot_temp_alert_o <= temp_err_ff;
    end
  end

endmodule
`default_nettype wire

// ---- mcr_regs_checker.sv ----
/*
  Port assertions of the monitor register bank.
  Assumes it is bound onto every mcr_regs instance.
*/
`timescale 1ns/100ps
`default_nettype none
module mcr_regs_checker #(
  parameter int TEMP_W = 9  // Temperature width
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [3:0] voltage_id_inputs_i,
  input wire logic       voltage_id_bit4_i,
  input wire logic       addr_strap_high_i,
  input wire logic       addr_strap_low_i,
  input wire logic       conv_done_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] first_fan_div_o,
  input wire logic [1:0] second_fan_div_o,
  input wire logic [7:0] bus_address_o,
  input wire logic       hot_temp_alert_o
);
  // One domain, reset disables all
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Field written to an offset shows on an output
  // Register takes the write at its edge, output copies it one edge later
  property p_wr_out(logic [7:0] ofs, int sel);
    reg_wr_i && reg_addr_i == ofs |-> ##2
      (sel == 0 ? first_fan_div_o == 2'($past(reg_wdata_i, 2) >> 4) :
       sel == 1 ? second_fan_div_o == 2'($past(reg_wdata_i, 2) >> 6) :
       bus_address_o == $past(reg_wdata_i, 2));
  endproperty
  a_div_first: assert property (p_wr_out(8'h47, 0)) else $error("first divisor not taken");
  a_div_second: assert property (p_wr_out(8'h47, 1)) else $error("second divisor not taken");
  a_addr_write: assert property (p_wr_out(8'h48, 2)) else $error("bus address not taken");
  a_addr_strap: assert property ($fell(rst_i) |-> ##[1:2]
    bus_address_o == {6'b001011, addr_strap_high_i, addr_strap_low_i}) else $error("strap address wrong");
  a_rd_vid: assert property (reg_rd_i && reg_addr_i == 8'h47 |=>
    reg_rdata_o[3:0] == $past(voltage_id_inputs_i)) else $error("id bits wrong");
  a_rd_bit4: assert property (reg_rd_i && reg_addr_i == 8'h49 |=>
    reg_rdata_o[0] == $past(voltage_id_bit4_i)) else $error("fifth id bit wrong");
  a_status_bits: assert property (reg_rd_i && reg_addr_i == 8'h41 |=>
    (reg_rdata_o & 8'hEF) == 8'h00) else $error("status spare bits set");
  a_rd_unmapped: assert property (reg_rd_i && reg_addr_i == 8'h50 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  a_alert_cause: assert property ($rose(hot_temp_alert_o) |-> $past(conv_done_i, 2))
    else $error("alert rose without conversion");
  a_alert_clear: assert property ((reg_rd_i && reg_addr_i == 8'h41 && !conv_done_i) ##1
    !conv_done_i [*3] |-> !hot_temp_alert_o) else $error("alert kept after status read");
  // Main scenarios
  c_alert: cover property (conv_done_i ##2 hot_temp_alert_o);
  c_clear: cover property (reg_rd_i && reg_addr_i == 8'h41 && hot_temp_alert_o);
  c_mode: cover property (reg_wr_i && reg_addr_i == 8'h4B && reg_wdata_i[1:0] == 2'b10);
endmodule
bind mcr_regs mcr_regs_checker #(.TEMP_W(TEMP_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .voltage_id_inputs_i(voltage_id_inputs_i), .voltage_id_bit4_i(voltage_id_bit4_i),
  .addr_strap_high_i(addr_strap_high_i), .addr_strap_low_i(addr_strap_low_i), .conv_done_i(conv_done_i),
  .reg_rdata_o(reg_rdata_o), .first_fan_div_o(first_fan_div_o), .second_fan_div_o(second_fan_div_o),
  .bus_address_o(bus_address_o), .hot_temp_alert_o(hot_temp_alert_o)
);
`default_nettype wire

// ---- mcr_host.sv ----
/*
  Host model that reaches the register bank.
  Assumes one-cycle strobes taken at clk_i rising edges.
*/
`timescale 1ns/100ps
`default_nettype none
module mcr_host (
  input  wire logic       clk_i,        // Bank clock
  input  wire logic [7:0] reg_rdata_i,  // Read data
  output var  logic [7:0] reg_addr_o,   // Offset
  output var  logic [7:0] reg_wdata_o,  // Write data
  output var  logic       reg_wr_o,     // Write strobe
  output var  logic       reg_rd_o      // Read strobe
);
  // Idle port at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end
  // test offset never used
  // Write strobe, then scrambled qualifiers
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask
  // Read strobe, data taken after the edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- monitor_config_registers_tb.sv ----
/*
  Self-checking bench of the monitor register bank.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module monitor_config_registers_tb;
  logic       clk_i = 1'b0;  // 200 MHz clock
  logic       rst_i = 1'b1;  // Reset, high
  logic [7:0] addr, wdata, rdata, bus_addr, rv;
  logic       wr, rd, alert;
  logic       conv = 1'b0;   // Conversion pulse
  logic [8:0] temp = 9'h000; // Temperature, half degrees
  logic [1:0] div1, div2;
  logic [3:0] voltage_id_inputs  = 4'h5;   // Id levels
  logic       voltage_id_bit4 = 1'b1;   // Fifth id level
  logic       strap_hi = 1'b1;  // Address strap high
  logic       strap_lo = 1'b0;  // Address strap low
  int         bad_count  = 0;
  int         n_compared = 0;
  mcr_regs #(.TEMP_W(9)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .voltage_id_inputs_i(voltage_id_inputs), .voltage_id_bit4_i(voltage_id_bit4), .addr_strap_high_i(strap_hi), .addr_strap_low_i(strap_lo),
    .temp_reading_i(temp), .conv_done_i(conv), .reg_rdata_o(rdata), .first_fan_div_o(div1),
    .second_fan_div_o(div2), .bus_address_o(bus_addr), .hot_temp_alert_o(alert));
  mcr_host u_host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd));
  // Free-running clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd_reg(a, rv);
    chk($sformatf("offset %h", a), rv, exp);
  endtask
  // One conversion pulse with a reading
  task automatic conv_at(input logic [7:0] t, input logic h);
    @(posedge clk_i);
    temp <= {t, h};
    conv <= 1'b1;
    @(posedge clk_i);
    conv <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // Set mode, convert, check alert and status
  task automatic step(input logic [1:0] m, input logic [7:0] t, input logic s);
    u_host.wr_reg(8'h4B, {6'h00, m});
    conv_at(t, 1'b0);
    chk("hot_temp_alert_o", {7'h00, alert}, {7'h00, s});
    rd_chk(8'h41, {3'h0, s, 4'h0});
  endtask
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Tests take about 1 us; cut a hang at 20 us
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("bus_address_o", bus_addr, 8'h2E);
    rd_chk(8'h48, 8'h2E);
    rd_chk(8'h49, 8'h81);
    rd_chk(8'h4B, 8'h01);
    rd_chk(8'h39, 8'h7F);
    rd_chk(8'h3A, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      u_host.wr_reg(8'h47, {i[1:0], 2'(3 - i), 4'hA});
      rd_chk(8'h47, {i[1:0], 2'(3 - i), voltage_id_inputs});
      chk("first_fan_div_o", {6'h00, div1}, {6'h00, 2'(3 - i)});
      chk("second_fan_div_o", {6'h00, div2}, {6'h00, i[1:0]});
    end
    u_host.wr_reg(8'h48, 8'h5A);
    rd_chk(8'h48, 8'h5A);
    chk("bus_address_o", bus_addr, 8'h5A);
    u_host.wr_reg(8'h49, 8'h00);
    rd_chk(8'h49, 8'h01);
    u_host.wr_reg(8'h49, 8'hFE);
    rd_chk(8'h49, 8'hFF);
    u_host.wr_reg(8'h50, 8'hFF);
    rd_chk(8'h50, 8'h00);
    u_host.wr_reg(8'h4B, 8'hFC);
    rd_chk(8'h4B, 8'h7C);
    $display("test register access done");
    u_host.wr_reg(8'h39, 8'h20);
    u_host.wr_reg(8'h3A, 8'h10);
    rd_chk(8'h39, 8'h20);
    rd_chk(8'h3A, 8'h10);
    step(2'b00, 8'h30, 1'b1);
    step(2'b00, 8'h18, 1'b1);
    step(2'b00, 8'h08, 1'b0);
    step(2'b00, 8'hE0, 1'b0);
    step(2'b01, 8'h30, 1'b1);
    step(2'b01, 8'h30, 1'b0);
    step(2'b01, 8'h08, 1'b1);
    step(2'b01, 8'h08, 1'b0);
    step(2'b01, 8'h30, 1'b1);
    step(2'b10, 8'h30, 1'b1);
    conv_at(8'h30, 1'b0);
    conv_at(8'h18, 1'b0);
    chk("hot_temp_alert_o", {7'h00, alert}, 8'h00);
    rd_chk(8'h41, 8'h00);
    step(2'b11, 8'h30, 1'b1);
    conv_at(8'h30, 1'b1);
    rd_chk(8'h4B, 8'h83);
    $display("test temperature modes done");
    // Second reset with new straps and new id levels
    @(posedge clk_i);
    voltage_id_inputs      <= 4'hC;
    voltage_id_bit4     <= 1'b0;
    strap_hi <= 1'b0;
    strap_lo <= 1'b1;
    rst_i    <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("bus_address_o", bus_addr, 8'h2D);
    chk("hot_temp_alert_o", {7'h00, alert}, 8'h00);
    rd_chk(8'h48, 8'h2D);
    rd_chk(8'h47, 8'h0C);
    rd_chk(8'h49, 8'h80);
    rd_chk(8'h41, 8'h00);
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
